/* File: rtl/mss_pkg.sv */
/*
 Constants, types and state layout for the multistep setpoint sequencer.
 Assumes a 50 MHz control clock and an APB slave with 32-bit data.
*/
// Operation
// - Sixteen signed step setpoints, -1000..+1000 tenths of percent, reset to zero.
// - As frequency source a setpoint is a percentage of maximum frequency.
// - As separated voltage source a setpoint is a percentage of rated voltage.
// - As process controller reference the setpoint passes through unscaled.
// - Terminal states pick the active step; an enabled sequencer that is not idle picks its stage instead.
// - Sequencer advances stages automatically by each stage's run duration.
// - Mode 0 stops after one pass; only a fresh run restarts.
// - Mode 1 keeps running at the last stage after one pass.
// - Mode 2 restarts from stage zero after each pass until stopped.
// - Power retention 0 forgets state; restart at stage zero after power returns.
// - Power retention 1 keeps stage and elapsed time across power loss.
// - Stop retention 0 makes every start begin at stage zero.
// - Stop retention 1 keeps the stage at stop and resumes there.
// - Each stage has a duration 0..65000 tenths of the unit, reset zero.
// - Each stage has a two-bit ramp set choice, reset zero.
// - One unit bit scales durations: 0 seconds, 1 hours.
// - Step zero source: table, three analog inputs, pulse, controller, preset.
// - With the preset source, up and down commands adjust the preset.
package mss_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int TENTH_S_NS = 100_000_000;
   localparam int TENTH_S_CYC = TENTH_S_NS / CLK_PERIOD_NS;
   localparam int TENTHS_S_PER_TENTH_H = 3600;

   localparam logic [7:0] OFS_SP = 8'h00;
   localparam logic [7:0] OFS_DUR = 8'h40;
   localparam logic [7:0] OFS_CFG = 8'h80;
   localparam logic [7:0] OFS_STAT = 8'h84;
   localparam logic [7:0] OFS_PRESET = 8'h88;
   localparam logic [7:0] OFS_ELAP = 8'h8c;

   localparam logic signed [10:0] SP_MAX = 11'sh3e8;
   localparam logic signed [10:0] SP_RST = 11'sh000;
   localparam logic [15:0] DUR_MAX = 16'hfde8;
   localparam logic [15:0] DUR_RST = 16'h0000;
   localparam logic [1:0] RS_RST = 2'h0;
   localparam int DUR_RS_LSB = 16;
   localparam int FULL_SCALE = 1000;

   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_PWR_BIT = 2;
   localparam int CFG_STOP_BIT = 3;
   localparam int CFG_UNIT_BIT = 4;
   localparam int CFG_SRC_LSB = 5;
   localparam int CFG_PLC_BIT = 8;
   localparam logic [8:0] CFG_RST = 9'h000;

   localparam logic [1:0] MODE_ONCE = 2'h0;
   localparam logic [1:0] MODE_HOLD = 2'h1;
   localparam logic [1:0] MODE_LOOP = 2'h2;

   localparam logic [2:0] SRC_TABLE = 3'h0;
   localparam logic [2:0] SRC_AI1 = 3'h1;
   localparam logic [2:0] SRC_AI2 = 3'h2;
   localparam logic [2:0] SRC_AI3 = 3'h3;
   localparam logic [2:0] SRC_PULSE = 3'h4;
   localparam logic [2:0] SRC_PID = 3'h5;
   localparam logic [2:0] SRC_PRESET = 3'h6;

   typedef enum logic [2:0] {
      A_NONE, A_SP, A_DUR, A_CFG, A_STAT, A_PRE, A_ELAP
   } mss_area_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_RUN = 4'h2,
      ST_HOLD = 4'h4,
      ST_PWR = 4'h8
   } mss_state_t;

   typedef struct packed {
      logic signed [10:0] analog_input_one;
      logic signed [10:0] analog_input_two;
      logic signed [10:0] analog_input_three;
      logic signed [10:0] pulse_input_terminal;
      logic signed [10:0] pid_out;
   } mss_src_t;

   typedef struct packed {
      logic signed [16:0] freq;
      logic signed [16:0] volt;
      logic signed [10:0] pid;
      logic [1:0] ramp;
      logic run;
      logic [3:0] stage;
   } mss_ref_t;

   typedef struct packed {
      logic [15:0][10:0] step_setpoint_table;
      logic [15:0][15:0] stage_duration;
      logic [15:0][1:0] stage_ramp_set_select;
      logic [1:0] sequence_end_mode;
      logic pwr_ret;
      logic stop_ret;
      logic stage_time_unit;
      logic [2:0] step0_source_select;
      logic plc_en;
      logic signed [10:0] preset_frequency;
      mss_state_t st;
      logic was_run;
      logic run_q;
      logic [3:0] stage;
      logic [15:0] elap;
      logic [31:0] tick;
      logic [11:0] hcnt;
      logic [3:0] sel_m;
      logic [3:0] sel_s;
      logic [2:0] up_q;
      logic [2:0] dn_q;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      mss_ref_t ref_o;
   } mss_st_t;
endpackage

/* File: rtl/mss_top.sv */
/*
 Multistep setpoint table and timed stage sequencer with APB registers.
 Assumes run, stop, power_fail and source values come from drive logic on pclk;
 selection terminals and up/down come from pins and are synchronised here.
*/
// Added by the designer: the address map and the APB register port.
`timescale 1ns/10ps
module mss_top
   import mss_pkg::*;
#(
   parameter int TICK_CYC = TENTH_S_CYC,
   parameter int HOUR_MULT = TENTHS_S_PER_TENTH_H
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Drive control
   input wire logic run_cmd,
   input wire logic stop_cmd,
   input wire logic power_fail,
   input wire logic [15:0] max_freq,
   input wire logic [15:0] rated_volt,
   input wire mss_src_t src_in,
   // Terminal pins
   input wire logic [3:0] sel_term,
   input wire logic up_cmd,
   input wire logic down_cmd,
   // References to the drive
   output mss_ref_t ref_out
);

   mss_st_t r;
   mss_st_t n;

   function automatic mss_area_t mss_decode(input logic [7:0] a);
      if (a[1:0] != 2'h0) begin
         return A_NONE;
      end else if (a >= OFS_SP && a < OFS_DUR) begin
         return A_SP;
      end else if (a >= OFS_DUR && a < OFS_CFG) begin
         return A_DUR;
      end else if (a == OFS_CFG) begin
         return A_CFG;
      end else if (a == OFS_STAT) begin
         return A_STAT;
      end else if (a == OFS_PRESET) begin
         return A_PRE;
      end else if (a == OFS_ELAP) begin
         return A_ELAP;
      end else begin
         return A_NONE;
      end
   endfunction

   function automatic logic [10:0] mss_clamp_sp(input logic [31:0] w);
      if ($signed(w) > $signed(32'(SP_MAX))) begin
         return SP_MAX;
      end else if ($signed(w) < -$signed(32'(SP_MAX))) begin
         return 11'(-SP_MAX);
      end else begin
         return w[10:0];
      end
   endfunction

   function automatic logic [16:0] mss_scale(input logic signed [10:0] sp, input logic [15:0] k);
      logic signed [27:0] p;
      p = 28'(sp * $signed({1'b0, k}));
      return 17'(p / FULL_SCALE);
   endfunction

   logic acc;
   logic wr_go;
   logic up_p;
   logic dn_p;
   logic start;
   mss_area_t area;
   logic [3:0] idx;
   logic [3:0] act;
   logic signed [10:0] spv;
   logic [15:0] dur_cur;

   always_comb begin
      n = r;
      acc = psel & penable;
      wr_go = acc & r.pready & pwrite;
      area = mss_decode(paddr);
      idx = paddr[5:2];
      up_p = r.up_q[1] & ~r.up_q[2];
      dn_p = r.dn_q[1] & ~r.dn_q[2];
      start = run_cmd & ~r.run_q & ~stop_cmd;
      dur_cur = r.stage_duration[r.stage];

      // Pin synchronisers and edge history
      n.sel_m = sel_term;
      n.sel_s = r.sel_m;
      n.up_q = {r.up_q[1:0], up_cmd};
      n.dn_q = {r.dn_q[1:0], down_cmd};
      n.run_q = run_cmd;

      // Step selection: sequencer stage while it owns the drive, else terminals
      if (r.plc_en && r.st != ST_IDLE) begin
         act = r.stage;
      end else begin
         act = r.sel_s;
      end
      if (act == 4'h0) begin
         case (r.step0_source_select)
            SRC_AI1: spv = src_in.analog_input_one;
            SRC_AI2: spv = src_in.analog_input_two;
            SRC_AI3: spv = src_in.analog_input_three;
            SRC_PULSE: spv = src_in.pulse_input_terminal;
            SRC_PID: spv = src_in.pid_out;
            SRC_PRESET: spv = r.preset_frequency;
            default: spv = $signed(r.step_setpoint_table[0]);
         endcase
      end else begin
         spv = $signed(r.step_setpoint_table[act]);
      end

      // Preset adjust by up/down; a bus write in the same cycle wins
      if (r.step0_source_select == SRC_PRESET) begin
         if (up_p && r.preset_frequency < SP_MAX) begin
            n.preset_frequency = r.preset_frequency + 11'sh001;
         end else if (dn_p && r.preset_frequency > -SP_MAX) begin
            n.preset_frequency = r.preset_frequency - 11'sh001;
         end
      end

      // APB: one wait state, then completion
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (acc && !r.pready) begin
         n.pready = 1'b1;
         n.pslverr = (area == A_NONE);
         if (area == A_SP) begin
            n.prdata = {{21{r.step_setpoint_table[idx][10]}}, r.step_setpoint_table[idx]};
         end else if (area == A_DUR) begin
            n.prdata = {14'h0, r.stage_ramp_set_select[idx], r.stage_duration[idx]};
         end else if (area == A_CFG) begin
            n.prdata = {23'h0, r.plc_en, r.step0_source_select, r.stage_time_unit,
                        r.stop_ret, r.pwr_ret, r.sequence_end_mode};
         end else if (area == A_STAT) begin
            n.prdata = {21'h0, act, r.st == ST_PWR, r.st == ST_HOLD, r.st == ST_RUN, r.stage};
         end else if (area == A_PRE) begin
            n.prdata = {{21{r.preset_frequency[10]}}, r.preset_frequency};
         end else if (area == A_ELAP) begin
            n.prdata = {16'h0, r.elap};
         end else begin
            n.prdata = 32'h0000_0000;
         end
      end
      if (wr_go) begin
         if (area == A_SP) begin
            n.step_setpoint_table[idx] = mss_clamp_sp(pwdata);
         end else if (area == A_DUR) begin
            n.stage_duration[idx] = (pwdata[15:0] > DUR_MAX) ? DUR_MAX : pwdata[15:0];
            n.stage_ramp_set_select[idx] = pwdata[DUR_RS_LSB +: 2];
         end else if (area == A_CFG) begin
            n.sequence_end_mode = pwdata[CFG_MODE_LSB +: 2];
            n.pwr_ret = pwdata[CFG_PWR_BIT];
            n.stop_ret = pwdata[CFG_STOP_BIT];
            n.stage_time_unit = pwdata[CFG_UNIT_BIT];
            n.step0_source_select = pwdata[CFG_SRC_LSB +: 3];
            n.plc_en = pwdata[CFG_PLC_BIT];
         end else if (area == A_PRE) begin
            n.preset_frequency = mss_clamp_sp(pwdata);
         end
      end

      // Sequencer
      case (r.st)
         ST_IDLE: begin
            if (power_fail) begin
               n.was_run = 1'b0;
               n.st = ST_PWR;
            end else if (start && r.plc_en) begin
               n.st = ST_RUN;
               if (!r.stop_ret) begin
                  n.stage = 4'h0;
               end
               n.elap = 16'h0000;
               n.tick = 32'h0;
               n.hcnt = 12'h000;
            end
         end
         ST_RUN: begin
            if (power_fail) begin
               n.was_run = 1'b1;
               n.st = ST_PWR;
            end else if (stop_cmd) begin
               n.st = ST_IDLE;
            end else if (r.elap >= dur_cur) begin
               n.elap = 16'h0000;
               n.tick = 32'h0;
               n.hcnt = 12'h000;
               if (r.stage == 4'hf) begin
                  if (r.sequence_end_mode == MODE_HOLD) begin
                     n.st = ST_HOLD;
                  end else if (r.sequence_end_mode == MODE_LOOP) begin
                     n.stage = 4'h0;
                  end else begin
                     n.st = ST_IDLE;
                     n.stage = 4'h0;
                  end
               end else begin
                  n.stage = r.stage + 4'h1;
               end
            end else if (r.tick == 32'(TICK_CYC - 1)) begin
               n.tick = 32'h0;
               if (!r.stage_time_unit || r.hcnt == 12'(HOUR_MULT - 1)) begin
                  n.hcnt = 12'h000;
                  n.elap = r.elap + 16'h0001;
               end else begin
                  n.hcnt = r.hcnt + 12'h001;
               end
            end else begin
               n.tick = r.tick + 32'h1;
            end
         end
         ST_HOLD: begin
            if (power_fail) begin
               n.was_run = 1'b1;
               n.st = ST_PWR;
            end else if (stop_cmd) begin
               n.st = ST_IDLE;
            end
         end
         ST_PWR: begin
            if (!power_fail) begin
               if (!r.pwr_ret) begin
                  n.stage = 4'h0;
                  n.elap = 16'h0000;
                  n.tick = 32'h0;
                  n.hcnt = 12'h000;
               end
               n.st = r.was_run ? ST_RUN : ST_IDLE;
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase

      // References to the drive
      n.ref_o.freq = mss_scale(spv, max_freq);
      n.ref_o.volt = mss_scale(spv, rated_volt);
      n.ref_o.pid = spv;
      n.ref_o.ramp = r.stage_ramp_set_select[act];
      n.ref_o.run = (r.st == ST_RUN) || (r.st == ST_HOLD);
      n.ref_o.stage = r.stage;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.st <= ST_IDLE;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign ref_out = r.ref_o;

endmodule

/* File: tb/mss_chk.sv */
/*
 Port-level assertion checker for mss_top.
 Bound from the testbench top file and sees only the top-level ports.
*/
`timescale 1ns/10ps
module mss_chk
   import mss_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Drive side
   input wire logic run_cmd,
   input wire logic stop_cmd,
   input wire logic power_fail,
   input wire mss_ref_t ref_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_RDY_PULSE: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   AST_RDY_ACCESS: assert property (pready |-> psel && penable && $past(penable))
      else $error("pready outside second access cycle");
   AST_ERR_MAP: assert property (pready && (paddr[1:0] != 2'h0 || paddr > 8'h8c) |-> pslverr)
      else $error("unmapped access without error");
   AST_ERR_RDY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_STOP: assert property (!power_fail ##1 (stop_cmd && !power_fail) [*2] |=> !ref_out.run)
      else $error("still running after stop");
   AST_STAGE_STEP: assert property ($changed(ref_out.stage) |->
      ref_out.stage == $past(ref_out.stage) + 4'h1 || ref_out.stage == 4'h0)
      else $error("stage skipped out of order");
   AST_STAGE_RUN: assert property ($changed(ref_out.stage) && ref_out.stage != 4'h0 |-> ref_out.run)
      else $error("stage advanced while not running");
   AST_RUN_CAUSE: assert property ($rose(ref_out.run) |-> $past(run_cmd, 2) || $past(power_fail, 3))
      else $error("run started without a run command");
   AST_ZERO_SP: assert property (ref_out.pid == 11'sh000 |->
      ref_out.freq == 17'sh00000 && ref_out.volt == 17'sh00000)
      else $error("zero setpoint gives nonzero reference");
endmodule

/* File: tb/mss_drv_mdl.sv */
/*
 Drive control and terminal model feeding mss_top.
 Tasks are called by the testbench; every change follows a rising pclk edge.
*/
`timescale 1ns/10ps
module mss_drv_mdl (
   // Clock
   input wire logic pclk,
   // Commands and terminal pins
   output logic run_cmd,
   output logic stop_cmd,
   output logic power_fail,
   output logic [3:0] sel_term,
   output logic up_cmd,
   output logic down_cmd
);
   initial begin
      run_cmd = 1'b0;
      stop_cmd = 1'b0;
      power_fail = 1'b0;
      sel_term = 4'h0;
      up_cmd = 1'b0;
      down_cmd = 1'b0;
   end
   task automatic start();
      @(posedge pclk) run_cmd <= 1'b1;
      repeat (2) @(posedge pclk);
      run_cmd <= 1'b0;
   endtask
   task automatic halt();
      @(posedge pclk) stop_cmd <= 1'b1;
      repeat (3) @(posedge pclk);
      stop_cmd <= 1'b0;
   endtask
   task automatic pfail(input int n);
      @(posedge pclk) power_fail <= 1'b1;
      repeat (n) @(posedge pclk);
      power_fail <= 1'b0;
   endtask
   task automatic pick(input logic [3:0] s);
      @(posedge pclk) sel_term <= s;
   endtask
   // Held long enough to pass the pin synchroniser
   task automatic bump(input logic up);
      @(posedge pclk) {up_cmd, down_cmd} <= {up, !up};
      repeat (4) @(posedge pclk);
      {up_cmd, down_cmd} <= 2'h0;
   endtask
endmodule

/* File: tb/mss_tb_top.sv */
/*
 Testbench top for mss_top: APB master, drive model, checker bind.
 Assumes TICK_CYC 4 and HOUR_MULT 3 to keep stage times short.
*/
`timescale 1ns/10ps
module mss_tb_top
   import mss_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic run_cmd, stop_cmd, power_fail, up_cmd, down_cmd;
   logic [3:0] sel_term;
   mss_ref_t ref_out;
   mss_src_t src_in = '{11'sh064, 11'sh0c8, 11'sh12c, 11'sh190, 11'sh1f4};
   logic [15:0] max_freq = 16'h0190;
   logic [15:0] rated_volt = 16'h017c;
   int err_count = 0;
   int samples_checked = 0;

   mss_top #(.TICK_CYC(4), .HOUR_MULT(3)) dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .run_cmd, .stop_cmd, .power_fail, .max_freq,
      .rated_volt, .src_in, .sel_term, .up_cmd, .down_cmd, .ref_out);
   mss_drv_mdl drv_u (.pclk, .run_cmd, .stop_cmd, .power_fail, .sel_term, .up_cmd, .down_cmd);

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk("pready", 32'h1, 32'h0);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(nm, x, q);
   endtask
   task automatic wait_st(input logic [3:0] s, input logic r);
      int n;
      n = 0;
      while ((ref_out.stage !== s || ref_out.run !== r) && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      chk("stage and run", {27'h0, r, s}, {27'h0, ref_out.run, ref_out.stage});
   endtask
   task automatic go(input logic [3:0] s);
      int n;
      n = 0;
      drv_u.start();
      while (ref_out.run !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk("start run and stage", {27'h0, 1'b1, s}, {27'h0, ref_out.run, ref_out.stage});
   endtask

   task automatic t_regs();
      rdc("sp0 reset", 8'h00, 32'h0);
      rdc("stage0 reset", 8'h40, 32'h0);
      rdc("cfg reset", 8'h80, 32'h0);
      apb(1'b1, 8'h00, 32'h7d0);
      rdc("sp high clamp", 8'h00, 32'h3e8);
      apb(1'b1, 8'h04, 32'hfffffc00);
      rdc("sp low clamp", 8'h04, 32'hfffffc18);
      apb(1'b1, 8'h44, 32'h0003_ffff);
      rdc("stage1 word", 8'h44, 32'h0003_fde8);
      apb(1'b1, 8'h44, 32'h0);
      apb(1'b0, 8'h90, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, e});
   endtask
   task automatic t_scale();
      apb(1'b1, 8'h0c, 32'h1f4);
      apb(1'b1, 8'h14, 32'hfffffeb3);
      drv_u.pick(4'h3);
      repeat (5) @(posedge pclk);
      chk("freq", 32'hc8, 32'(signed'(ref_out.freq)));
      chk("volt", 32'hbe, 32'(signed'(ref_out.volt)));
      chk("pid", 32'h1f4, 32'(signed'(ref_out.pid)));
      drv_u.pick(4'h5);
      repeat (5) @(posedge pclk);
      chk("neg freq", 32'hffffff7b, 32'(signed'(ref_out.freq)));
      chk("neg volt", 32'hffffff82, 32'(signed'(ref_out.volt)));
      max_freq <= 16'hffff;
      rated_volt <= 16'h0000;
      repeat (3) @(posedge pclk);
      chk("full scale freq", 32'hffffaac1, 32'(signed'(ref_out.freq)));
      chk("zero volt", 32'h0, 32'(signed'(ref_out.volt)));
      drv_u.pick(4'h0);
   endtask
   task automatic t_src();
      logic [10:0] v[5] = '{11'h064, 11'h0c8, 11'h12c, 11'h190, 11'h1f4};
      for (int i = 1; i <= 5; i++) begin
         apb(1'b1, 8'h80, 32'(i) << 5);
         repeat (4) @(posedge pclk);
         chk("source value", {21'h0, v[i-1]}, 32'(signed'(ref_out.pid)));
      end
      src_in <= '{11'h79c, 11'h7ce, 11'h738, 11'h706, 11'h7f9};
      repeat (3) @(posedge pclk);
      chk("live source", 32'hfffffff9, 32'(signed'(ref_out.pid)));
      apb(1'b1, 8'h88, 32'h2a);
      apb(1'b1, 8'h80, 32'hc0);
      drv_u.bump(1'b1);
      repeat (6) @(posedge pclk);
      chk("preset up", 32'h2b, 32'(signed'(ref_out.pid)));
      drv_u.bump(1'b0);
      repeat (6) @(posedge pclk);
      chk("preset down", 32'h2a, 32'(signed'(ref_out.pid)));
      apb(1'b1, 8'h80, 32'h0);
      repeat (4) @(posedge pclk);
      chk("table source", 32'h3e8, 32'(signed'(ref_out.pid)));
      apb(1'b1, 8'h80, 32'he0);
      repeat (4) @(posedge pclk);
      chk("unused source code", 32'h3e8, 32'(signed'(ref_out.pid)));
   endtask
   task automatic t_once();
      int n;
      apb(1'b1, 8'h40, 32'h0002_0002);
      apb(1'b1, 8'h4c, 32'h14);
      apb(1'b1, 8'h80, 32'h100);
      go(4'h0);
      chk("ramp set", 32'h2, {30'h0, ref_out.ramp});
      wait_st(4'h3, 1'b1);
      wait_st(4'h0, 1'b0);
      repeat (20) @(posedge pclk);
      chk("stays stopped", 32'h0, {31'h0, ref_out.run});
      apb(1'b1, 8'h80, 32'h110);
      go(4'h0);
      n = 0;
      while (ref_out.stage === 4'h0 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      chk("hour stage length", 32'h1, {31'h0, n > 21 && n < 28});
      wait_st(4'h0, 1'b0);
   endtask
   task automatic t_modes();
      apb(1'b1, 8'h80, 32'h101);
      go(4'h0);
      wait_st(4'hf, 1'b1);
      repeat (20) @(posedge pclk);
      chk("hold", 32'h1f, {27'h0, ref_out.run, ref_out.stage});
      rdc("hold status", 8'h84, 32'h7af);
      drv_u.halt();
      wait_st(4'hf, 1'b0);
      apb(1'b1, 8'h80, 32'h102);
      go(4'h0);
      wait_st(4'hf, 1'b1);
      wait_st(4'h0, 1'b1);
      wait_st(4'h3, 1'b1);
      apb(1'b1, 8'h80, 32'h10a);
      drv_u.halt();
      wait_st(4'h3, 1'b0);
      go(4'h3);
   endtask
   task automatic t_power();
      apb(1'b1, 8'h80, 32'h10e);
      drv_u.pfail(6);
      chk("frozen", 32'h0, {31'h0, ref_out.run});
      repeat (3) @(posedge pclk);
      chk("resume", 32'h13, {27'h0, ref_out.run, ref_out.stage});
      apb(1'b1, 8'h80, 32'h10a);
      drv_u.pfail(6);
      repeat (3) @(posedge pclk);
      chk("restart", 32'h10, {27'h0, ref_out.run, ref_out.stage});
      drv_u.halt();
      wait_st(4'h0, 1'b0);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_scale();
      t_src();
      t_once();
      t_modes();
      t_power();
      stop_test();
   end
   initial begin
      #1_900_000;
      err_count++;
      stop_test();
   end
endmodule

bind mss_top mss_chk chk_u (.pclk, .presetn, .paddr, .psel, .penable, .pready, .pslverr, .run_cmd,
   .stop_cmd, .power_fail, .ref_out);
